/* File: shared/rpss_pkg.sv */
// Shared constants and types for the reset pin state sequencer
package rpss_pkg;
    // Operating modes as strapped on the mode pins
    typedef enum logic [2:0] {
        RPSS_MODE_1 = 3'b001,
        RPSS_MODE_2 = 3'b010,
        RPSS_MODE_3 = 3'b011,
        RPSS_MODE_4 = 3'b100,
        RPSS_MODE_7 = 3'b111
    } rpss_mode_e;

    // Sequencer phases after the clear input is sampled low
    typedef enum logic [1:0] {
        RPSS_RUN   = 2'b00,
        RPSS_HALF  = 2'b01,
        RPSS_FULL  = 2'b10,
        RPSS_HELD  = 2'b11
    } rpss_state_e;

    localparam int RPSS_CLK_PERIOD_PS = 25000;
    // Delays in tenths of a system clock period
    localparam int RPSS_CLK_DELAY_TENTHS = 5;
    localparam int RPSS_BUS_DELAY_TENTHS = 15;
    // Whole edges after the sampling edge; half periods round up
    localparam int RPSS_CLK_DELAY_CYC = (RPSS_CLK_DELAY_TENTHS + 9) / 10;
    localparam int RPSS_BUS_DELAY_CYC = (RPSS_BUS_DELAY_TENTHS + 9) / 10;

    localparam int RPSS_ADDR_W = 20;
    localparam int RPSS_LOW_W = 8;
    localparam int RPSS_MID_W = 8;
    localparam int RPSS_PAGE_W = 4;
    localparam int RPSS_DATA_W = 8;
    localparam int RPSS_PORT_W = 64;

    // Bus strobes, all active low
    typedef struct packed {
        logic address_valid_n;
        logic data_strobe_n;
        logic read_strobe_n;
        logic store_strobe_n;
    } rpss_strobe_s;

    localparam rpss_strobe_s RPSS_STROBE_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};
endpackage

/* File: design/rpss_sequencer.sv */
// Pin sequencer driving bus, clock and port pins through a clear and standby
`timescale 1ns/100ps
module rpss_sequencer
    import rpss_pkg::*;
(
    input wire logic i_clk,                           // System clock, 40 MHz
    input wire logic i_rst,                           // Power-on reset, async high
    input wire logic i_external_clear_in_n,           // Clear pin, active low
    input wire logic i_standby_request_n,             // Standby pin, active low
    input wire logic [2:0] i_mode,                    // Mode straps
    input wire rpss_strobe_s i_strobe,                // Core strobes in normal running
    input wire logic i_dir_read,                      // Core direction, high for read
    input wire logic [RPSS_ADDR_W-1:0] i_addr,        // Core address
    input wire logic [RPSS_DATA_W-1:0] i_data,        // Core write data
    input wire logic i_data_drive,                    // Core drives data bus
    input wire logic [RPSS_PORT_W-1:0] i_port_out,    // Core port data
    input wire logic [RPSS_PORT_W-1:0] i_port_dir,    // Core port direction, 1 output
    output logic o_core_reset,                        // Core held in reset
    output logic o_standby,                           // Hardware standby active
    output rpss_strobe_s o_strobe,                    // Bus strobes
    output logic o_dir_read,                          // Transfer direction, high read
    output logic [RPSS_ADDR_W-1:0] o_addr,            // Address pins
    output logic [RPSS_ADDR_W-1:0] o_addr_oe_n,       // Address enables, low drives
    output logic [RPSS_DATA_W-1:0] o_data,            // Data pins
    output logic o_data_oe_n,                         // Data enable, low drives
    output logic [RPSS_PORT_W-1:0] o_port_out,        // Port pins
    output logic [RPSS_PORT_W-1:0] o_port_oe_n,       // Port enables, low drives
    output logic [1:0] o_clk_oe_n                     // Clock pin enables, low drives
);
    localparam int LOW_HI = RPSS_LOW_W - 1;
    localparam int MID_HI = RPSS_LOW_W + RPSS_MID_W - 1;

    function automatic logic is_ext(input logic [2:0] m);
        is_ext = (m == RPSS_MODE_1) || (m == RPSS_MODE_2) || (m == RPSS_MODE_3) || (m == RPSS_MODE_4);
    endfunction

    function automatic logic is_full_addr(input logic [2:0] m);
        is_full_addr = (m == RPSS_MODE_1) || (m == RPSS_MODE_3);
    endfunction

    // Clear pin is also an async assert so pins release without a clock
    logic clr_async;
    assign clr_async = i_rst | ~i_external_clear_in_n;

    logic sync1_q;
    logic sync2_q;
    rpss_state_e state_q;
    logic [2:0] mode_q;

    // Release edge goes through two flops; assertion is async
    always_ff @(posedge i_clk or posedge clr_async) begin
        if (clr_async) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= 1'b1;
            sync2_q <= sync1_q;
        end
    end

    // Mode straps caught while clear is held, after power-on reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= RPSS_MODE_7;
        end else if (!sync2_q) begin
            mode_q <= i_mode;
        end
    end

    // Separate sampled-low flop counts delays from the sampling edge
    logic samp1_q;
    logic samp_low_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            samp1_q <= 1'b0;
            samp_low_q <= 1'b1;
        end else begin
            samp1_q <= i_external_clear_in_n;
            samp_low_q <= ~samp1_q;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= RPSS_HELD;
        end else begin
            case (state_q)
                RPSS_RUN: state_q <= samp_low_q ? RPSS_HALF : RPSS_RUN;
                RPSS_HALF: state_q <= RPSS_FULL;
                RPSS_FULL: state_q <= RPSS_HELD;
                RPSS_HELD: state_q <= (sync2_q && !samp_low_q) ? RPSS_RUN : RPSS_HELD;
                default: state_q <= RPSS_HELD;
            endcase
        end
    end

    logic clk_on;
    logic bus_init;
    assign clk_on = (state_q != RPSS_RUN) || sync2_q;
    assign bus_init = (state_q == RPSS_FULL) || (state_q == RPSS_HELD);

    // Pins that react without a clock
    always_ff @(posedge i_clk or posedge clr_async) begin
        if (clr_async) begin
            o_port_oe_n <= '1;
            o_port_out <= '0;
            o_strobe <= RPSS_STROBE_IDLE;
            o_data_oe_n <= 1'b1;
            o_data <= '0;
            o_core_reset <= 1'b1;
        end else begin
            o_port_oe_n <= ~i_port_dir;
            o_port_out <= i_port_out;
            o_strobe <= is_ext(mode_q) ? i_strobe : RPSS_STROBE_IDLE;
            o_data_oe_n <= ~(is_ext(mode_q) && i_data_drive);
            o_data <= i_data;
            o_core_reset <= ~sync2_q;
        end
    end

    logic [LOW_HI:0] addr_oe_lo_q;
    logic [RPSS_ADDR_W-LOW_HI-2:0] addr_oe_hi_q;
    logic upper_rel;

    // Address, direction and clock pins follow the sampled sequence
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_addr <= '0;
            addr_oe_lo_q <= '1;
            o_dir_read <= 1'b1;
            o_clk_oe_n <= 2'b11;
        end else begin
            o_clk_oe_n <= clk_on ? 2'b00 : 2'b11;
            if (state_q == RPSS_RUN && !samp_low_q) begin
                o_addr <= i_addr;
                o_dir_read <= i_dir_read;
                addr_oe_lo_q <= is_ext(mode_q) ? '0 : '1;
            end else if (bus_init && is_ext(mode_q)) begin
                o_dir_read <= 1'b1;
                o_addr[LOW_HI:0] <= '0;
                addr_oe_lo_q <= '0;
                if (is_full_addr(mode_q)) begin
                    o_addr <= '0;
                end
            end else if (!is_ext(mode_q)) begin
                addr_oe_lo_q <= '1;
            end
        end
    end

    // Upper and page lines are ports in the narrow modes, so they let go without waiting for a clock
    assign upper_rel = i_rst | (~i_external_clear_in_n & ~is_full_addr(mode_q));

    always_ff @(posedge i_clk or posedge upper_rel) begin
        if (upper_rel) begin
            addr_oe_hi_q <= '1;
        end else if (state_q == RPSS_RUN && !samp_low_q) begin
            addr_oe_hi_q <= is_ext(mode_q) ? '0 : '1;
        end else if (bus_init && is_full_addr(mode_q)) begin
            addr_oe_hi_q <= '0;
        end else if (!is_full_addr(mode_q)) begin
            addr_oe_hi_q <= '1;
        end
    end

    assign o_addr_oe_n = {addr_oe_hi_q, addr_oe_lo_q};

    // Standby passes through; sequencing before it is the controller's job
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_standby <= 1'b0;
        end else begin
            o_standby <= ~i_standby_request_n;
        end
    end
endmodule // rpss_sequencer

/* File: verification/rpss_seq_sva.sv */
// Concurrent checks on the reset pin state sequencer ports
`timescale 1ns/100ps
module rpss_seq_sva
    import rpss_pkg::*;
(
    input wire logic i_clk, // Clock
    input wire logic i_rst, // Reset
    input wire logic i_external_clear_in_n, // Clear pin
    input wire logic [2:0] i_mode, // Mode straps
    input wire logic [63:0] i_port_out, // Core port data
    input wire logic [63:0] i_port_dir, // Core port direction
    input wire logic [7:0] i_data, // Core write data
    input wire logic [63:0] o_port_out, // Port pins
    input wire logic [7:0] o_data, // Data pins
    input wire logic o_core_reset, // Core reset
    input wire rpss_strobe_s o_strobe, // Strobes
    input wire logic o_dir_read, // Direction
    input wire logic [19:0] o_addr, // Address
    input wire logic [19:0] o_addr_oe_n, // Address enables
    input wire logic o_data_oe_n, // Data enable
    input wire logic [63:0] o_port_oe_n, // Port enables
    input wire logic [1:0] o_clk_oe_n // Clock enables
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic clr = !i_external_clear_in_n;
    wire logic m13 = i_mode == 3'h1 || i_mode == 3'h3;
    wire logic m24 = i_mode == 3'h2 || i_mode == 3'h4;
    port_release_a: assert property (clr |-> o_port_oe_n == '1) else $error("ports driven in clear");
    strobe_idle_a: assert property (clr |-> o_strobe == RPSS_STROBE_IDLE) else $error("strobe active");
    data_release_a: assert property (clr |-> o_data_oe_n) else $error("data driven in clear");
    full_bus_init_a: assert property (($fell(i_external_clear_in_n) && m13) ##1 clr [*4] |=>
        o_addr == '0 && o_addr_oe_n == '0 && o_dir_read) else $error("full bus not initialised");
    low_bus_init_a: assert property ($fell(i_external_clear_in_n) && m24 |->
        ##5 o_addr[7:0] == 8'h0 && o_addr_oe_n[7:0] == 8'h0 && o_dir_read) else $error("low bus bad");
    upper_release_a: assert property ($fell(i_external_clear_in_n) && m24 |->
        o_addr_oe_n[15:8] == 8'hff) else $error("upper lines driven");
    page_release_a: assert property ($fell(i_external_clear_in_n) && i_mode == 3'h4 |->
        o_addr_oe_n[19:16] == 4'hf) else $error("page lines driven");
    core_follow_a: assert property (!clr ##1 !clr |-> o_port_out == $past(i_port_out) &&
        o_data == $past(i_data) && o_port_oe_n == ~$past(i_port_dir)) else $error("pins do not follow core");
    clk_enable_a: assert property ($fell(i_external_clear_in_n) |-> ##4 o_clk_oe_n == 2'h0)
        else $error("clock pins not enabled");
    mode7_quiet_a: assert property (i_mode == 3'h7 && !o_core_reset |->
        o_addr_oe_n == '1 && o_data_oe_n && o_strobe == RPSS_STROBE_IDLE) else $error("bus used in mode 7");
    cover property ($fell(i_external_clear_in_n) && m13);
    cover property ($fell(i_external_clear_in_n) && i_mode == 3'h4);
    cover property ($fell(i_external_clear_in_n) && i_mode == 3'h7);
endmodule // rpss_seq_sva

/* File: verification/rpss_board_model.sv */
// Board controller model driving the clear and standby pins
`timescale 1ns/100ps
module rpss_board_model (
    input wire logic i_clk, // System clock
    output logic o_clear_n, // Clear pin
    output logic o_standby_n // Standby pin
);
    initial begin
        o_clear_n = 1'b1;
        o_standby_n = 1'b1;
    end
    task automatic clear(input logic on);
        @(negedge i_clk);
        o_clear_n = !on;
    endtask
    // Skipping the clear lead loses RAM contents
    task automatic sleep(input logic keep);
        if (keep) clear(1'b1);
        repeat (10) @(negedge i_clk);
        o_standby_n = 1'b0;
        clear(1'b0);
    endtask
    task automatic wake();
        clear(1'b1);
        repeat (4) @(negedge i_clk);
        o_standby_n = 1'b1;
        clear(1'b0);
    endtask
endmodule // rpss_board_model

/* File: verification/test_rpss_sequencer.sv */
// Self-checking testbench for the reset pin state sequencer
`timescale 1ns/100ps
module test_rpss_sequencer;
    import rpss_pkg::*;
    typedef logic [113:0] rpss_obs_t;
    localparam rpss_obs_t ONES70 = {{70{1'b1}}, 44'h0};
    logic i_clk, i_rst, i_dir_read, i_data_drive, o_core_reset, o_standby, o_dir_read, o_data_oe_n;
    logic [2:0] i_mode;
    logic [7:0] i_data;
    logic [19:0] i_addr, o_addr, o_addr_oe_n;
    logic [63:0] i_port_out, i_port_dir, o_port_oe_n;
    logic [1:0] o_clk_oe_n;
    logic [31:0] seed = 32'h2f12;
    rpss_strobe_s i_strobe, o_strobe;
    wire logic clear_n, standby_n;
    rpss_obs_t q[$], e_v, m_v;
    int error_cnt = 0;
    int checks = 0;
    event smp;
    logic [2:0] md [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [19:0] ae [5] = '{20'h0, 20'h0ff00, 20'h0, 20'hfff00, 20'hfffff};
    logic [19:0] am [5] = '{20'hfffff, 20'h0ffff, 20'hfffff, 20'hfffff, 20'hfffff};
    logic [19:0] dm [5] = '{20'hfffff, 20'h000ff, 20'hfffff, 20'h000ff, 20'h0};
    wire rpss_obs_t seen = {o_port_oe_n, o_data_oe_n, o_strobe, o_core_reset, o_addr_oe_n, o_addr, o_dir_read,
        o_clk_oe_n, o_standby};
    rpss_board_model u_board (.i_clk, .o_clear_n(clear_n), .o_standby_n(standby_n));
    rpss_sequencer u_dut (.i_clk, .i_rst, .i_external_clear_in_n(clear_n), .i_standby_request_n(standby_n),
        .i_mode, .i_strobe, .i_dir_read, .i_addr, .i_data, .i_data_drive, .i_port_out, .i_port_dir, .o_core_reset,
        .o_standby, .o_strobe, .o_dir_read, .o_addr, .o_addr_oe_n, .o_data(), .o_data_oe_n, .o_port_out(),
        .o_port_oe_n, .o_clk_oe_n);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic drive(input int n);
        repeat (n) begin
            @(negedge i_clk);
            i_port_out = {rnd(), rnd()};
            i_port_dir = {rnd(), rnd()};
            {i_dir_read, i_data_drive, i_strobe, i_data, i_addr} = {rnd(), 2'h0};
        end
    endtask
    task automatic check(input rpss_obs_t got, input rpss_obs_t exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: pins %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic expect_obs(input rpss_obs_t e, input rpss_obs_t m);
        q.push_back(e);
        q.push_back(m);
        ->smp;
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always begin
        @(smp);
        e_v = q.pop_front();
        m_v = q.pop_front();
        check(seen & m_v, e_v & m_v);
    end
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        #20000;
        error_cnt++;
        finish_test();
    end
    initial begin
        i_rst = 1'b1;
        i_mode = 3'h7;
        {i_port_out, i_port_dir, i_dir_read, i_data_drive, i_strobe, i_data, i_addr} = '0;
        #50 i_rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            u_board.clear(1'b1);
            i_mode = md[i];
            u_board.clear(1'b0);
            drive(6);
            expect_obs('0, {69'h0, 1'b1, 44'h0});
            drive(4);
            u_board.clear(1'b1);
            #1 expect_obs(ONES70, ONES70);
            repeat (5) @(negedge i_clk);
            expect_obs(ONES70 | {70'h0, ae[i], 20'h0, 4'h8}, ONES70 | {70'h0, am[i], dm[i], i != 4, 3'h6});
        end
        for (int k = 0; k < 2; k++) begin
            u_board.sleep(k == 0);
            expect_obs(114'h1, 114'h1);
            u_board.wake();
            @(negedge i_clk);
            expect_obs(114'h0, 114'h1);
        end
        finish_test();
    end
endmodule // test_rpss_sequencer
bind rpss_sequencer rpss_seq_sva u_sva (.i_clk, .i_rst, .i_external_clear_in_n, .i_mode, .i_port_out, .i_port_dir,
    .i_data, .o_port_out, .o_data, .o_core_reset, .o_strobe, .o_dir_read, .o_addr, .o_addr_oe_n, .o_data_oe_n,
    .o_port_oe_n, .o_clk_oe_n);
